/* smbcr_host_model.sv */
// SMBus host model that issues indexed block writes and block reads.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module smbcr_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // ----------------------------------------------------------------
  // Bit timing in clock cycles (440 ns half period)
  // ----------------------------------------------------------------
  localparam int HALF = 110;
  localparam int HOLD = 25;

  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(negedge i_clk);
  endtask

  // ----------------------------------------------------------------
  // Framing: start, repeated start, stop
  // ----------------------------------------------------------------
  task automatic start();
    o_sda_low = 1'b0;
    wt(HALF - HOLD);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_low = 1'b1;
    wt(HALF);
    o_scl = 1'b0;
    wt(HOLD);
  endtask

  task automatic stop();
    o_sda_low = 1'b1;
    wt(HOLD);
    o_scl = 1'b1;
    wt(HALF);
    o_sda_low = 1'b0;
    wt(HALF);
  endtask

  // One bit: data set while clock low, sampled mid high
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = ~b;
    wt(HALF - HOLD);
    o_scl = 1'b1;
    wt(HALF / 2);
    r = i_sda;
    wt(HALF - HALF / 2);
    o_scl = 1'b0;
    wt(HOLD);
  endtask

  // Byte out MSB first, device acknowledges in ninth bit
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Byte in MSB first, host acks all but the last
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

/* smbcr_pkg.sv */
// Constants, types and register map for the SMBus output control bank.
// Assumes a single 250 MHz clock and synchronous active-high reset.
package smbcr_pkg;

  // ----------------------------------------------------------------
  // Clock and bus timing
  // ----------------------------------------------------------------
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          SDA_HOLD_NS   = 300;
  localparam int          SDA_HOLD_INT  = (SDA_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0]  SDA_HOLD_CYC  = 7'(SDA_HOLD_INT);
  localparam logic [6:0]  SLAVE_ADDR    = 7'h6E;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_OUT_EN_LO  = 8'h01;
  localparam logic [7:0] IDX_OUT_EN_HI  = 8'h02;
  localparam logic [7:0] IDX_PIN_RB_LO  = 8'h03;
  localparam logic [7:0] IDX_PIN_RB_HI  = 8'h04;
  localparam logic [7:0] IDX_VEND_REV   = 8'h05;
  localparam logic [7:0] IDX_PART_ID    = 8'h06;
  localparam logic [7:0] IDX_RD_COUNT   = 8'h07;

  // ----------------------------------------------------------------
  // Reset values and identification
  // ----------------------------------------------------------------
  localparam logic [7:0]  RST_OUT_EN_LO = 8'hFF;
  localparam logic [7:0]  RST_OUT_EN_HI = 8'h0F;
  localparam logic [7:0]  RST_RD_COUNT  = 8'h07;
  // Identification values are arbitrary
  localparam logic [3:0]  VENDOR_CODE   = 4'hA;
  localparam logic [3:0]  REVISION_CODE = 4'h3;
  localparam logic [7:0]  RST_PART_ID   = 8'h5A;
  localparam logic [1:0]  RST_BUS_IDLE  = 2'h3;
  localparam logic [11:0] RST_PIN_N     = 12'hFFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_RX   = 3'h1,
    S_ACK  = 3'h2,
    S_ACKD = 3'h3,
    S_TXW  = 3'h4,
    S_TX   = 3'h5,
    S_HREL = 3'h6,
    S_HACK = 3'h7
  } smbcr_state_e;

  typedef enum logic [1:0] {
    K_ADDR  = 2'h0,
    K_INDEX = 2'h1,
    K_COUNT = 2'h2,
    K_DATA  = 2'h3
  } smbcr_kind_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } smbcr_bus_s;

endpackage

/* smbcr_sync.sv */
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are asynchronous to i_clk.
`timescale 1ns/1ps
module smbcr_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_srst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);

  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta_q <= RST;
      sync_q <= RST;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

/* smbcr_top.sv */
// SMBus slave with the output enable, pin readback, ident and count bank.
// Assumes SCL and SDA arrive as pins; SDA is open drain, pulled up outside.
// Behaviour
// - Index 1 holds software enables for outputs 7..0, 1 allows, 0 floats, reset all ones.
// - Index 2 bits 3..0 enable outputs 11..8 (reset 1); bits 7..4 are writable, reset 0.
// - Index 3 reads the live active-low enable pins of outputs 7..0.
// - Index 4 reads the pins of outputs 11..8 in bits 3..0, upper bits read 0.
// - An output is driven only when its software bit is 1 and its pin is 0.
// - Index 5 returns a fixed vendor code in bits 7..4 and revision code in bits 3..0.
// - Index 7 is a writable count returned first on a block read, reset to 7.
// - A block write sends index, count, then data stored at consecutive indices, all acked.
// - A block read returns the count byte, then consecutive bytes until the host nacks.
`timescale 1ns/1ps
module smbcr_top (
  input  wire logic        i_clk,
  input  wire logic        i_srst,
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  input  wire logic [11:0] i_out_enable_pin_n,
  output logic             o_sda,
  output logic             o_sda_oe,
  output logic      [11:0] o_clk_out_pair_en
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  smbcr_pkg::smbcr_bus_s bus_s;
  logic [1:0]            bus_raw;
  logic [11:0]           pin_n_s;

  smbcr_sync #(.W(2), .RST(smbcr_pkg::RST_BUS_IDLE)) u_bus_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async ({i_scl, i_sda}),
    .o_sync  (bus_raw)
  );

  smbcr_sync #(.W(12), .RST(smbcr_pkg::RST_PIN_N)) u_pin_sync (
    .i_clk   (i_clk),
    .i_srst  (i_srst),
    .i_async (i_out_enable_pin_n),
    .o_sync  (pin_n_s)
  );

  assign bus_s = smbcr_pkg::smbcr_bus_s'(bus_raw);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  smbcr_pkg::smbcr_state_e state_q, state_d;
  smbcr_pkg::smbcr_kind_e  kind_q,  kind_d;
  logic [7:0]  sh_q,      sh_d;
  logic [2:0]  bit_q,     bit_d;
  logic [7:0]  idx_q,     idx_d;
  logic [7:0]  cnt_q,     cnt_d;
  logic        rw_q,      rw_d;
  logic        scl_p_q,   sda_p_q;
  logic        pend_q,    pend_d;
  logic [6:0]  hold_q,    hold_d;
  logic        sda_oe_q,  sda_oe_d;
  logic [7:0]  en_lo_q,   en_lo_d;
  logic [7:0]  en_hi_q,   en_hi_d;
  logic [7:0]  part_id_q, part_id_d;
  logic [7:0]  count_q,   count_d;
  logic [11:0] drive_q,   drive_d;
  logic [7:0]  rd_data;
  logic        wr_en;
  logic        scl_rise, scl_fall, bus_start, bus_stop;

  assign scl_rise  = bus_s.scl & ~scl_p_q;
  assign scl_fall  = ~bus_s.scl & scl_p_q;
  assign bus_start = bus_s.scl & scl_p_q & sda_p_q & ~bus_s.sda;
  assign bus_stop  = bus_s.scl & scl_p_q & ~sda_p_q & bus_s.sda;

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  always_comb begin
    case (idx_q)
      smbcr_pkg::IDX_OUT_EN_LO: rd_data = en_lo_q;
      smbcr_pkg::IDX_OUT_EN_HI: rd_data = en_hi_q;
      smbcr_pkg::IDX_PIN_RB_LO: rd_data = pin_n_s[7:0];
      smbcr_pkg::IDX_PIN_RB_HI: rd_data = {4'h0, pin_n_s[11:8]};
      smbcr_pkg::IDX_VEND_REV:  rd_data = {smbcr_pkg::VENDOR_CODE, smbcr_pkg::REVISION_CODE};
      smbcr_pkg::IDX_PART_ID:   rd_data = part_id_q;
      smbcr_pkg::IDX_RD_COUNT:  rd_data = count_q;
      default:                  rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // Bus engine and register writes
  // ----------------------------------------------------------------
  always_comb begin
    state_d   = state_q;
    kind_d    = kind_q;
    sh_d      = sh_q;
    bit_d     = bit_q;
    idx_d     = idx_q;
    cnt_d     = cnt_q;
    rw_d      = rw_q;
    pend_d    = pend_q;
    hold_d    = hold_q;
    sda_oe_d  = sda_oe_q;
    en_lo_d   = en_lo_q;
    en_hi_d   = en_hi_q;
    part_id_d = part_id_q;
    count_d   = count_q;
    wr_en     = 1'b0;
    if (hold_q != 7'h00) begin
      hold_d = hold_q - 7'h01;
      if (hold_q == 7'h01) begin
        sda_oe_d = pend_q;
      end
    end
    if (bus_start) begin
      state_d  = smbcr_pkg::S_RX;
      kind_d   = smbcr_pkg::K_ADDR;
      bit_d    = 3'h0;
      pend_d   = 1'b0;
      hold_d   = 7'h00;
      sda_oe_d = 1'b0;
    end else if (bus_stop) begin
      state_d  = smbcr_pkg::S_IDLE;
      pend_d   = 1'b0;
      hold_d   = 7'h00;
      sda_oe_d = 1'b0;
    end else begin
      if (scl_rise) begin
        case (state_q)
          smbcr_pkg::S_RX: begin
            sh_d  = {sh_q[6:0], bus_s.sda};
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              state_d = smbcr_pkg::S_ACK;
              case (kind_q)
                smbcr_pkg::K_ADDR: begin
                  if (sh_d[7:1] == smbcr_pkg::SLAVE_ADDR) begin
                    rw_d = sh_d[0];
                    if (!sh_d[0]) begin
                      kind_d = smbcr_pkg::K_INDEX;
                    end
                  end else begin
                    state_d = smbcr_pkg::S_IDLE;
                  end
                end
                smbcr_pkg::K_INDEX: begin
                  idx_d  = sh_d;
                  kind_d = smbcr_pkg::K_COUNT;
                end
                smbcr_pkg::K_COUNT: begin
                  cnt_d  = sh_d;
                  kind_d = smbcr_pkg::K_DATA;
                end
                default: begin
                  if (cnt_q != 8'h00) begin
                    wr_en = 1'b1;
                    idx_d = idx_q + 8'h01;
                    cnt_d = cnt_q - 8'h01;
                  end
                end
              endcase
            end
          end
          smbcr_pkg::S_TX: begin
            bit_d = bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              state_d = smbcr_pkg::S_HREL;
            end
          end
          smbcr_pkg::S_HACK: begin
            if (!bus_s.sda) begin
              sh_d    = rd_data;
              idx_d   = idx_q + 8'h01;
              state_d = smbcr_pkg::S_TXW;
            end else begin
              state_d = smbcr_pkg::S_IDLE;
            end
          end
          default: ;
        endcase
      end
      if (scl_fall) begin
        hold_d = smbcr_pkg::SDA_HOLD_CYC;
        case (state_q)
          smbcr_pkg::S_ACK: begin
            pend_d  = 1'b1;
            state_d = smbcr_pkg::S_ACKD;
          end
          smbcr_pkg::S_ACKD: begin
            bit_d = 3'h0;
            if (kind_q == smbcr_pkg::K_ADDR && rw_q) begin
              sh_d    = count_q;
              pend_d  = ~count_q[7];
              state_d = smbcr_pkg::S_TX;
            end else begin
              pend_d  = 1'b0;
              state_d = smbcr_pkg::S_RX;
            end
          end
          smbcr_pkg::S_TX: begin
            sh_d   = {sh_q[6:0], 1'b0};
            pend_d = ~sh_q[6];
          end
          smbcr_pkg::S_HREL: begin
            pend_d  = 1'b0;
            state_d = smbcr_pkg::S_HACK;
          end
          smbcr_pkg::S_TXW: begin
            pend_d  = ~sh_q[7];
            bit_d   = 3'h0;
            state_d = smbcr_pkg::S_TX;
          end
          default: pend_d = 1'b0;
        endcase
      end
    end
    if (wr_en) begin
      case (idx_q)
        smbcr_pkg::IDX_OUT_EN_LO: en_lo_d   = sh_d;
        smbcr_pkg::IDX_OUT_EN_HI: en_hi_d   = sh_d;
        smbcr_pkg::IDX_PART_ID:   part_id_d = sh_d;
        smbcr_pkg::IDX_RD_COUNT:  count_d   = sh_d;
        default: ;
      endcase
    end
    drive_d = {en_hi_q[3:0], en_lo_q} & ~pin_n_s;
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state_q   <= smbcr_pkg::S_IDLE;
      kind_q    <= smbcr_pkg::K_ADDR;
      sh_q      <= 8'h00;
      bit_q     <= 3'h0;
      idx_q     <= 8'h00;
      cnt_q     <= 8'h00;
      rw_q      <= 1'b0;
      scl_p_q   <= 1'b1;
      sda_p_q   <= 1'b1;
      pend_q    <= 1'b0;
      hold_q    <= 7'h00;
      sda_oe_q  <= 1'b0;
      en_lo_q   <= smbcr_pkg::RST_OUT_EN_LO;
      en_hi_q   <= smbcr_pkg::RST_OUT_EN_HI;
      part_id_q <= smbcr_pkg::RST_PART_ID;
      count_q   <= smbcr_pkg::RST_RD_COUNT;
      drive_q   <= 12'h000;
    end else begin
      state_q   <= state_d;
      kind_q    <= kind_d;
      sh_q      <= sh_d;
      bit_q     <= bit_d;
      idx_q     <= idx_d;
      cnt_q     <= cnt_d;
      rw_q      <= rw_d;
      scl_p_q   <= bus_s.scl;
      sda_p_q   <= bus_s.sda;
      pend_q    <= pend_d;
      hold_q    <= hold_d;
      sda_oe_q  <= sda_oe_d;
      en_lo_q   <= en_lo_d;
      en_hi_q   <= en_hi_d;
      part_id_q <= part_id_d;
      count_q   <= count_d;
      drive_q   <= drive_d;
    end
  end

  logic sda_zero_q;
  always_ff @(posedge i_clk) begin
    sda_zero_q <= 1'b0;
  end

  assign o_sda             = sda_zero_q;
  assign o_sda_oe          = sda_oe_q;
  assign o_clk_out_pair_en = drive_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);

  property p_reset_values;
    $fell(i_srst) |-> (en_lo_q == 8'hFF && en_hi_q == 8'h0F && count_q == 8'h07
                       && part_id_q == smbcr_pkg::RST_PART_ID);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("bad reset value");

  property p_lo_write;
    (wr_en && idx_q == 8'h01) |=> en_lo_q == $past(sh_d);
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("enable low write lost");

  property p_hi_write;
    (wr_en && idx_q == 8'h02) |=> en_hi_q == $past(sh_d);
  endproperty
  a_hi_write: assert property (p_hi_write) else $error("enable high write lost");

  property p_pin_lo;
    (idx_q == 8'h03) |-> rd_data == pin_n_s[7:0];
  endproperty
  a_pin_lo: assert property (p_pin_lo) else $error("pin readback low wrong");

  property p_pin_hi;
    (idx_q == 8'h04) |-> (rd_data[7:4] == 4'h0 && rd_data[3:0] == pin_n_s[11:8]);
  endproperty
  a_pin_hi: assert property (p_pin_hi) else $error("pin readback high wrong");

  property p_drive;
    o_clk_out_pair_en == ({$past(en_hi_q[3:0]), $past(en_lo_q)} & ~$past(pin_n_s));
  endproperty
  a_drive: assert property (p_drive) else $error("output drive mismatch");

  property p_ident;
    (idx_q == 8'h05) |-> rd_data == {smbcr_pkg::VENDOR_CODE, smbcr_pkg::REVISION_CODE};
  endproperty
  a_ident: assert property (p_ident) else $error("ident byte wrong");

  property p_count_first;
    (state_q == smbcr_pkg::S_ACKD && scl_fall && rw_q && kind_q == smbcr_pkg::K_ADDR)
      |=> (sh_q == count_q && state_q == smbcr_pkg::S_TX);
  endproperty
  a_count_first: assert property (p_count_first) else $error("count not sent first");

  property p_ro_write;
    (wr_en && (idx_q == 8'h03 || idx_q == 8'h04 || idx_q == 8'h05))
      |=> ($stable(en_lo_q) && $stable(en_hi_q) && $stable(part_id_q) && $stable(count_q));
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("read-only write changed state");

  property p_ack_hold;
    (scl_fall && state_q == smbcr_pkg::S_ACK && !bus_start && !bus_stop)
      |-> ##76 o_sda_oe;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("ack not driven after hold");

  c_write: cover property (wr_en && idx_q == 8'h01);
  c_read:  cover property (state_q == smbcr_pkg::S_HACK && scl_rise && !bus_s.sda);
  c_stop:  cover property (bus_stop && state_q != smbcr_pkg::S_IDLE);

endmodule

/* tb_smbcr_top.sv */
// Self-checking bench for the SMBus output control register bank.
// Assumes smbcr_pkg and the host model are compiled first.
`timescale 1ns/1ps
module tb_smbcr_top;
  logic        i_clk;
  logic        i_srst;
  logic        scl;
  logic        host_low;
  logic        sda_w;
  logic [11:0] pins_n;
  logic        o_sda;
  logic        o_sda_oe;
  logic [11:0] en;
  logic [7:0]  m_reg [0:7];
  logic [7:0]  dat [0:7];
  logic        ack;
  integer      seed;
  int          err_total;
  int          n_tests;

  // ----------------------------------------------------------------
  // Clock, wire and instances
  // ----------------------------------------------------------------
  always #2 i_clk = ~i_clk;
  assign sda_w = ~host_low & ~(o_sda_oe & ~o_sda);

  smbcr_top u_smbcr_top (
    .i_clk              (i_clk),
    .i_srst             (i_srst),
    .i_scl              (scl),
    .i_sda              (sda_w),
    .i_out_enable_pin_n (pins_n),
    .o_sda              (o_sda),
    .o_sda_oe           (o_sda_oe),
    .o_clk_out_pair_en  (en)
  );

  smbcr_host_model u_smbcr_host_model (
    .i_clk     (i_clk),
    .i_sda     (sda_w),
    .o_scl     (scl),
    .o_sda_low (host_low)
  );

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t ns got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] rd_exp(input logic [7:0] idx);
    case (idx)
      smbcr_pkg::IDX_PIN_RB_LO: rd_exp = pins_n[7:0];
      smbcr_pkg::IDX_PIN_RB_HI: rd_exp = {4'h0, pins_n[11:8]};
      smbcr_pkg::IDX_VEND_REV:  rd_exp = {smbcr_pkg::VENDOR_CODE, smbcr_pkg::REVISION_CODE};
      8'h01, 8'h02, 8'h06, 8'h07: rd_exp = m_reg[idx[2:0]];
      default: rd_exp = 8'h00;
    endcase
  endfunction

  task automatic en_chk();
    repeat (4) @(negedge i_clk);
    chk(en, {m_reg[2][3:0], m_reg[1]} & ~pins_n);
  endtask

  // ----------------------------------------------------------------
  // Block transfers
  // ----------------------------------------------------------------
  task automatic blk_write(input logic [7:0] idx, input int n);
    logic [7:0] b;
    logic [7:0] j;
    u_smbcr_host_model.start();
    for (int i = 0; i < n + 3; i++) begin
      b = (i == 0) ? {smbcr_pkg::SLAVE_ADDR, 1'b0} : (i == 1) ? idx :
          (i == 2) ? 8'(n) : dat[i-3];
      u_smbcr_host_model.wr_byte(b, ack);
      chk(12'(ack), 12'h001);
      j = idx + 8'(i - 3);
      if (i > 2 && (j == 1 || j == 2 || j == 6 || j == 7)) begin
        m_reg[j[2:0]] = b;
      end
    end
    u_smbcr_host_model.stop();
  endtask

  task automatic blk_read(input logic [7:0] idx, input int n);
    logic [7:0] b;
    u_smbcr_host_model.start();
    u_smbcr_host_model.wr_byte({smbcr_pkg::SLAVE_ADDR, 1'b0}, ack);
    chk(12'(ack), 12'h001);
    u_smbcr_host_model.wr_byte(idx, ack);
    chk(12'(ack), 12'h001);
    u_smbcr_host_model.start();
    u_smbcr_host_model.wr_byte({smbcr_pkg::SLAVE_ADDR, 1'b1}, ack);
    chk(12'(ack), 12'h001);
    u_smbcr_host_model.rd_byte(1'b0, b);
    chk(12'(b), 12'(m_reg[7]));
    for (int k = 0; k < n; k++) begin
      u_smbcr_host_model.rd_byte(k == n - 1, b);
      chk(12'(b), 12'(rd_exp(idx + 8'(k))));
    end
    u_smbcr_host_model.stop();
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (95000) @(posedge i_clk);
    err_total++;
    end_of_test();
  end

  initial begin
    seed = 67;
    i_clk = 1'b0;
    i_srst = 1'b1;
    pins_n = 12'h000;
    err_total = 0;
    n_tests = 0;
    foreach (m_reg[i]) m_reg[i] = 8'h00;
    m_reg[1] = smbcr_pkg::RST_OUT_EN_LO;
    m_reg[2] = smbcr_pkg::RST_OUT_EN_HI;
    m_reg[6] = smbcr_pkg::RST_PART_ID;
    m_reg[7] = smbcr_pkg::RST_RD_COUNT;
    repeat (4) @(negedge i_clk);
    i_srst = 1'b0;
    repeat (4) @(negedge i_clk);
    en_chk();
    pins_n = 12'($random(seed));
    en_chk();
    blk_read(8'h01, 7);
    dat[0] = 8'($random(seed));
    dat[1] = 8'($random(seed));
    blk_write(8'h01, 2);
    pins_n = 12'hFFF;
    en_chk();
    pins_n = 12'h000;
    en_chk();
    pins_n = 12'($random(seed));
    en_chk();
    for (int k = 0; k < 5; k++) dat[k] = 8'($random(seed));
    blk_write(8'h03, 5);
    u_smbcr_host_model.start();
    u_smbcr_host_model.wr_byte(8'hD4, ack);
    chk(12'(ack), 12'h000);
    u_smbcr_host_model.stop();
    pins_n = 12'($random(seed));
    repeat (4) @(negedge i_clk);
    blk_read(8'h01, 7);
    en_chk();
    end_of_test();
  end
endmodule
